// File: common/fsr_pkg.sv
// shared constants and types for the flash status register read block
package fsr_pkg;

    // serial command code of the status read
    localparam logic [7:0] OPC_READ_STATUS = 8'h05;

    // serial byte framing
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // bit positions, byte one
    localparam int B1_PROTECT_LOCK = 7;
    localparam int B1_PE_ERROR = 5;
    localparam int B1_WP_PIN = 4;
    localparam int B1_WEL = 1;
    localparam int B_READY_BUSY = 0;

    // bit positions, byte two
    localparam int B2_RESET_EN = 4;
    localparam int B2_LOCKDOWN_EN = 3;

    // bits that the two status write commands may change
    localparam logic [7:0] B1_WR_MASK = 8'h80;
    localparam logic [7:0] B2_WR_MASK = 8'h18;

    // reset values
    localparam logic PROTECT_LOCK_RST = 1'b0;
    localparam logic RESET_EN_RST = 1'b0;
    localparam logic LOCKDOWN_EN_RST = 1'b0;
    localparam logic [1:0] SOFT_PROTECT_ALL = 2'h3;
    localparam logic RES_BIT_VAL = 1'b0;
    localparam logic [2:0] B2_RES_HI_VAL = 3'h0;
    localparam logic [1:0] B2_RES_LO_VAL = 2'h0;
    localparam logic WP_PIN_IDLE = 1'b1;

    typedef struct packed {
        logic protect_regs_lock;
        logic reserved_bit;
        logic program_erase_error;
        logic write_protect_pin_state;
        logic [1:0] soft_protect_summary;
        logic write_enable_latch;
        logic ready_busy_flag;
    } fsr_byte_one_t;

    typedef struct packed {
        logic [2:0] reserved_hi;
        logic reset_cmd_enable;
        logic lockdown_cmd_enable;
        logic [1:0] reserved_lo;
        logic ready_busy_flag;
    } fsr_byte_two_t;

    typedef struct packed {
        fsr_byte_one_t status_byte_one;
        fsr_byte_two_t status_byte_two;
    } fsr_status_t;

endpackage : fsr_pkg

// File: rtl/fsr_sync.sv
// two flip-flop level synchroniser with synchronous reset
`timescale 1ns/1ps
module fsr_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic d,
    output logic q
);

    logic meta;
    logic next_meta;
    logic next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
        if (srst) begin
            next_meta = RST_VAL;
            next_q = RST_VAL;
        end
    end

    always_ff @(posedge clk) begin
        meta <= next_meta;
        q <= next_q;
    end

endmodule : fsr_sync

// File: rtl/fsr_status_read.sv
// two-byte flash status register and its serial status read command
//
// Function
// [RQ1] after chip select and opcode 05h, status bits leave on every following clock
// [RQ2] after byte two the device starts again with byte one while selected
// [RQ3] each repeated byte carries freshly sampled status, ready/busy in both bytes
// [RQ4] status read is accepted at any time, also during program or erase
// [RQ5] above the status clock limit the host reads at least four bytes
// [RQ6] chip select release at any bit ends the read, output goes high-z
// [RQ7] byte one bit 7 is the writable protection register lock, default 0
// [RQ8] byte one bit 5 is the read-only program/erase error flag
// [RQ9] byte one bit 4 reads 0 with protect pin asserted, 1 when deasserted
// [RQ10] byte one bits 3:2 summarise software protection, default all protected
// [RQ11] byte one bit 1 shows the write enable latch, default 0
// [RQ12] bit 0 of both bytes is ready/busy, 1 while busy
// [RQ13] reserved bits are read-only; byte two reserved bits read 0
// [RQ14] byte two bit 4 is the writable reset command enable, default 0
// [RQ15] byte two bit 3 is the writable lockdown command enable, default 0
// [RQ16] byte one write changes only bit 7
// [RQ17] byte two write changes only bits 4 and 3
// [RQ18] host polls status until ready/busy falls from 1 to 0
// [RQ19] each status byte goes out most significant bit first
`timescale 1ns/1ps
module fsr_status_read (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic wp_n_pin,
    input wire logic core_busy,
    input wire logic core_pe_error,
    input wire logic core_wel,
    input wire logic [1:0] core_soft_protect,
    input wire logic wr_byte_one_stb,
    input wire logic wr_byte_two_stb,
    input wire logic [7:0] wr_data,
    input wire logic freeze_lockdown_stb,
    output logic protect_regs_lock,
    output logic reset_cmd_enable,
    output logic lockdown_cmd_enable
);

    typedef enum logic [1:0] {
        ST_OPCODE,
        ST_STATUS,
        ST_IGNORE
    } fsr_link_state_t;

    // keep old bits outside the mask, take new bits inside it
    function automatic logic [7:0] fsr_merge(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] mask
    );
        fsr_merge = (old_val & ~mask) | (new_val & mask);
    endfunction : fsr_merge

    // ---------------- system clock domain ----------------

    logic wp_n_s;
    logic ack_s;
    logic frozen;
    logic next_protect_regs_lock;
    logic next_reset_cmd_enable;
    logic next_lockdown_cmd_enable;
    logic next_frozen;
    fsr_pkg::fsr_status_t live;
    fsr_pkg::fsr_status_t snap;
    fsr_pkg::fsr_status_t next_snap;
    logic snap_tgl;
    logic next_snap_tgl;
    logic [7:0] b1_merged;
    logic [7:0] b2_merged;

    // link side acknowledge, toggled when it has taken a snapshot
    logic tgl_seen;

    fsr_sync #(
        .RST_VAL(fsr_pkg::WP_PIN_IDLE)
    ) u_wp_sync (
        .clk(sys_clk),
        .srst(srst),
        .d(wp_n_pin),
        .q(wp_n_s)
    );

    fsr_sync #(
        .RST_VAL(1'b0)
    ) u_ack_sync (
        .clk(sys_clk),
        .srst(srst),
        .d(tgl_seen),
        .q(ack_s)
    );

    // live status as the core sees it right now
    always_comb begin
        live.status_byte_one.protect_regs_lock = protect_regs_lock; // [RQ7]
        live.status_byte_one.reserved_bit = fsr_pkg::RES_BIT_VAL; // [RQ13]
        live.status_byte_one.program_erase_error = core_pe_error; // [RQ8]
        live.status_byte_one.write_protect_pin_state = wp_n_s; // [RQ9]
        live.status_byte_one.soft_protect_summary = core_soft_protect; // [RQ10]
        live.status_byte_one.write_enable_latch = core_wel; // [RQ11]
        live.status_byte_one.ready_busy_flag = core_busy; // [RQ12]
        live.status_byte_two.reserved_hi = fsr_pkg::B2_RES_HI_VAL; // [RQ13]
        live.status_byte_two.reset_cmd_enable = reset_cmd_enable; // [RQ14]
        live.status_byte_two.lockdown_cmd_enable = lockdown_cmd_enable; // [RQ15]
        live.status_byte_two.reserved_lo = fsr_pkg::B2_RES_LO_VAL; // [RQ13]
        live.status_byte_two.ready_busy_flag = core_busy; // [RQ12]
    end

    // register writes from the command decoder of the core
    always_comb begin
        b1_merged = fsr_merge(live.status_byte_one, wr_data, fsr_pkg::B1_WR_MASK); // [RQ16]
        b2_merged = fsr_merge(live.status_byte_two, wr_data, fsr_pkg::B2_WR_MASK); // [RQ17]
        next_protect_regs_lock = protect_regs_lock;
        next_reset_cmd_enable = reset_cmd_enable;
        next_lockdown_cmd_enable = lockdown_cmd_enable;
        next_frozen = frozen;
        if (wr_byte_one_stb) begin
            // with the protect pin asserted the lock may only be set, never cleared
            if (!wp_n_s) begin
                next_protect_regs_lock = protect_regs_lock
                    | b1_merged[fsr_pkg::B1_PROTECT_LOCK]; // [RQ7]
            end else begin
                next_protect_regs_lock = b1_merged[fsr_pkg::B1_PROTECT_LOCK]; // [RQ7]
            end
        end
        if (wr_byte_two_stb) begin
            next_reset_cmd_enable = b2_merged[fsr_pkg::B2_RESET_EN]; // [RQ14]
            next_lockdown_cmd_enable = b2_merged[fsr_pkg::B2_LOCKDOWN_EN]; // [RQ15]
        end
        // a frozen lockdown state pins the enable low until power cycle
        if (freeze_lockdown_stb) begin
            next_frozen = 1'b1;
        end
        if (freeze_lockdown_stb || frozen) begin
            next_lockdown_cmd_enable = 1'b0;
        end
        if (srst) begin
            next_protect_regs_lock = fsr_pkg::PROTECT_LOCK_RST;
            next_reset_cmd_enable = fsr_pkg::RESET_EN_RST;
            next_lockdown_cmd_enable = fsr_pkg::LOCKDOWN_EN_RST;
            next_frozen = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        protect_regs_lock <= next_protect_regs_lock;
        reset_cmd_enable <= next_reset_cmd_enable;
        lockdown_cmd_enable <= next_lockdown_cmd_enable;
        frozen <= next_frozen;
    end

    // snapshot handshake: the snapshot only changes once the link side
    // has acknowledged the previous one, so it is stable while captured
    always_comb begin
        next_snap = snap;
        next_snap_tgl = snap_tgl;
        if (ack_s == snap_tgl) begin
            next_snap = live; // [RQ3] [RQ4]
            next_snap_tgl = ~snap_tgl;
        end
        if (srst) begin
            next_snap = live;
            next_snap_tgl = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        snap <= next_snap;
        snap_tgl <= next_snap_tgl;
    end

    // ---------------- serial clock domain ----------------
    // the link clock stands still outside frames, so chip select high is
    // the asynchronous reset of everything here; all flops take constants

    fsr_link_state_t state;
    fsr_link_state_t next_state;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] opc_shift;
    logic [7:0] next_opc_shift;
    logic [7:0] opc_full;
    logic [7:0] cur_byte;
    logic [7:0] next_cur_byte;
    logic send_two;
    logic next_send_two;
    logic tl_meta;
    logic tl_sync;
    logic next_tl_meta;
    logic next_tl_sync;
    logic next_tgl_seen;
    fsr_pkg::fsr_status_t hold;
    fsr_pkg::fsr_status_t next_hold;
    logic next_miso;
    logic next_miso_oe;

    always_comb begin
        next_tl_meta = snap_tgl;
        next_tl_sync = tl_meta;
        next_hold = hold;
        next_tgl_seen = tgl_seen;
        // take a new snapshot whenever one has been offered
        if (tl_sync != tgl_seen) begin
            next_hold = snap; // [RQ3]
            next_tgl_seen = tl_sync;
        end
        next_state = state;
        next_bit_cnt = bit_cnt + 3'h1;
        opc_full = {opc_shift[6:0], mosi};
        next_opc_shift = opc_shift;
        next_cur_byte = cur_byte;
        next_send_two = send_two;
        case (state)
            ST_OPCODE: begin
                next_opc_shift = opc_full;
                if (bit_cnt == fsr_pkg::BIT_LAST) begin
                    if (opc_full == fsr_pkg::OPC_READ_STATUS) begin
                        next_state = ST_STATUS; // [RQ1] [RQ4]
                        next_cur_byte = hold.status_byte_one;
                        next_send_two = 1'b1;
                    end else begin
                        next_state = ST_IGNORE;
                    end
                end
            end
            ST_STATUS: begin
                if (bit_cnt == fsr_pkg::BIT_LAST) begin
                    // alternate bytes, each loaded from the newest snapshot
                    if (send_two) begin
                        next_cur_byte = hold.status_byte_two; // [RQ2] [RQ3]
                    end else begin
                        next_cur_byte = hold.status_byte_one; // [RQ2] [RQ3]
                    end
                    next_send_two = ~send_two;
                end
            end
            ST_IGNORE: begin
                next_state = ST_IGNORE;
            end
            default: begin
                next_state = ST_IGNORE;
            end
        endcase
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            state <= ST_OPCODE; // [RQ6]
            bit_cnt <= fsr_pkg::BIT_FIRST;
            opc_shift <= 8'h00;
            cur_byte <= 8'h00;
            send_two <= 1'b0;
            tl_meta <= 1'b0;
            tl_sync <= 1'b0;
            tgl_seen <= 1'b0;
            hold <= '0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            opc_shift <= next_opc_shift;
            cur_byte <= next_cur_byte;
            send_two <= next_send_two;
            tl_meta <= next_tl_meta;
            tl_sync <= next_tl_sync;
            tgl_seen <= next_tgl_seen;
            hold <= next_hold;
        end
    end

    // output changes on the falling edge so the host samples on the rising one
    always_comb begin
        next_miso = 1'b0;
        next_miso_oe = 1'b0;
        if (state == ST_STATUS) begin
            next_miso = cur_byte[fsr_pkg::BIT_LAST - bit_cnt]; // [RQ19] [RQ1]
            next_miso_oe = 1'b1;
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            miso <= 1'b0; // [RQ6]
            miso_oe <= 1'b0; // [RQ6]
        end else begin
            miso <= next_miso;
            miso_oe <= next_miso_oe;
        end
    end

endmodule : fsr_status_read

// File: tb/fsr_status_read_props.sv
// assertions on the status register block ports
`timescale 1ns/1ps
module fsr_status_read_props (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic wr_byte_one_stb,
    input wire logic wr_byte_two_stb,
    input wire logic [7:0] wr_data,
    input wire logic freeze_lockdown_stb,
    input wire logic protect_regs_lock,
    input wire logic reset_cmd_enable,
    input wire logic lockdown_cmd_enable
);
    logic [3:0] cnt;
    logic [7:0] sh;
    // saturates so a long frame never wraps back into a false count of 9
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt <= 4'h0;
            sh <= 8'h00;
        end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
            sh <= {sh[6:0], mosi};
        end
    end
    property p_rst_vals;
        @(posedge sys_clk) srst |=> !protect_regs_lock && !reset_cmd_enable && !lockdown_cmd_enable;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values");
    property p_lock_set;
        @(posedge sys_clk) disable iff (srst) wr_byte_one_stb && wr_data[7] |=> protect_regs_lock;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set");
    property p_lock_hold;
        @(posedge sys_clk) disable iff (srst) !wr_byte_one_stb |=> $stable(protect_regs_lock);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock moved");
    property p_reset_cmd_enable_write;
        @(posedge sys_clk) disable iff (srst)
            wr_byte_two_stb |=> reset_cmd_enable == $past(wr_data[4]);
    endproperty
    a_reset_cmd_enable_write: assert property (p_reset_cmd_enable_write) else $error("reset enable");
    property p_lde_rise;
        @(posedge sys_clk) disable iff (srst)
            $rose(lockdown_cmd_enable) |-> $past(wr_byte_two_stb) && $past(wr_data[3]);
    endproperty
    a_lde_rise: assert property (p_lde_rise) else $error("lockdown rose");
    property p_lde_freeze;
        @(posedge sys_clk) disable iff (srst) freeze_lockdown_stb |=> !lockdown_cmd_enable [*8];
    endproperty
    a_lde_freeze: assert property (p_lde_freeze) else $error("freeze");
    property p_oe_idle;
        @(posedge sys_clk) disable iff (srst) cs_n |-> !miso_oe && !miso;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output while deselected");
    property p_oe_start;
        @(negedge sclk) disable iff (cs_n)
            cnt == 4'h9 |-> miso_oe == ($past(sh) == fsr_pkg::OPC_READ_STATUS);
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("output start");
    c_read: cover property (@(negedge sclk) $rose(miso_oe));
    c_freeze: cover property (@(posedge sys_clk) freeze_lockdown_stb);
    c_lock: cover property (@(posedge sys_clk) $rose(protect_regs_lock));
endmodule : fsr_status_read_props
bind fsr_status_read fsr_status_read_props u_props (.sys_clk, .srst, .sclk, .cs_n, .mosi,
    .miso, .miso_oe, .wr_byte_one_stb, .wr_byte_two_stb, .wr_data, .freeze_lockdown_stb,
    .protect_regs_lock, .reset_cmd_enable, .lockdown_cmd_enable);

// File: tb/fsr_host.sv
// serial host model: status read frames and byte capture
`timescale 1ns/1ps
module fsr_host (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    output logic rx_stb,
    output logic [7:0] rx_data,
    output int rx_idx,
    output logic oe_seen
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        mosi = 1'b0;
        rx_stb = 1'b0;
        // a clean rising edge once every process waits, so the link side starts reset
        #1;
        cs_n = 1'b1;
    end
    // sclk rests low between frames; nbits counts the command bits too
    task automatic frame(input logic [7:0] op, input int nbits);
        int i;
        #37;
        cs_n = 1'b0;
        oe_seen = 1'b0;
        rx_idx = -1;
        for (i = 0; i < nbits; i++) begin
            mosi = (i < 8) ? op[7 - i] : ~mosi;
            #80;
            sclk = 1'b1;
            rx_data = {rx_data[6:0], miso};
            oe_seen = oe_seen | (miso_oe && i > 7);
            rx_stb = (i % 8 == 7) && i > 8;
            rx_idx += rx_stb;
            #80;
            sclk = 1'b0;
            rx_stb = 1'b0;
        end
        #40;
        cs_n = 1'b1;
    endtask : frame
endmodule : fsr_host

// File: tb/fsr_status_read_tb_top.sv
// self-checking bench for the flash status register read block
`timescale 1ns/1ps
module fsr_status_read_tb_top;
    logic sys_clk = 1'b0, srst = 1'b1, wp_n_pin = 1'b1, core_busy = 1'b0, core_wel = 1'b0;
    logic core_pe_error = 1'b0, freeze_lockdown_stb = 1'b0;
    logic wr_byte_one_stb = 1'b0, wr_byte_two_stb = 1'b0;
    logic lock_m = 1'b0, rst_m = 1'b0, lde_m = 1'b0, frz_m = 1'b0;
    logic [1:0] core_soft_protect = 2'h3;
    logic [7:0] wr_data = 8'h00;
    logic sclk, cs_n, mosi, miso, miso_oe, protect_regs_lock, reset_cmd_enable;
    logic lockdown_cmd_enable, rx_stb, oe_seen;
    logic [7:0] rx_data;
    logic [7:0] exp_q[$];
    int rx_idx, k, r, error_cnt = 0, cmp_count = 0;
    fsr_status_read uut (.sys_clk, .srst, .sclk, .cs_n, .mosi, .miso, .miso_oe, .wp_n_pin,
        .core_busy, .core_pe_error, .core_wel, .core_soft_protect, .wr_byte_one_stb,
        .wr_byte_two_stb, .wr_data, .freeze_lockdown_stb, .protect_regs_lock,
        .reset_cmd_enable, .lockdown_cmd_enable);
    fsr_host host (.sclk, .cs_n, .mosi, .miso, .miso_oe, .rx_stb, .rx_data, .rx_idx, .oe_seen);
    initial forever #5 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic two, input logic [7:0] d);
        @(posedge sys_clk);
        wr_byte_one_stb <= !two;
        wr_byte_two_stb <= two;
        wr_data <= d;
        @(posedge sys_clk);
        wr_byte_one_stb <= 1'b0;
        wr_byte_two_stb <= 1'b0;
        if (!two && (wp_n_pin || d[7])) lock_m = d[7];
        if (two) rst_m = d[4];
        if (two) lde_m = d[3] & !frz_m;
    endtask : wr
    // the first two bytes of a frame may be stale, so notes start at byte 2
    task automatic rd(input logic [7:0] o, input int nbits);
        int i;
        // registers settle after the write edge, so look half a cycle later
        @(negedge sys_clk);
        chk("lock out", {7'h0, lock_m}, {7'h0, protect_regs_lock});
        chk("reset enable out", {7'h0, rst_m}, {7'h0, reset_cmd_enable});
        chk("lockdown enable out", {7'h0, lde_m}, {7'h0, lockdown_cmd_enable});
        for (i = 2; i < (nbits - 8) / 8; i++) begin
            if (o == fsr_pkg::OPC_READ_STATUS) exp_q.push_back(i % 2 ?
                {3'h0, rst_m, lde_m, 2'h0, core_busy} :
                {lock_m, 1'b0, core_pe_error, wp_n_pin, core_soft_protect, core_wel, core_busy});
        end
        host.frame(o, nbits);
        @(posedge sys_clk);
        chk("unread notes", 8'h00, 8'(exp_q.size()));
        chk("oe after release", 8'h00, {7'h0, miso_oe});
    endtask : rd
    initial begin
        forever begin
            @(posedge rx_stb);
            if (rx_idx >= 2 && exp_q.size() != 0) begin
                chk("status byte", exp_q.pop_front(), rx_data);
            end
        end
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        error_cnt++;
        final_report();
    end
    initial begin
        r = $urandom(7);
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        rd(fsr_pkg::OPC_READ_STATUS, 56);
        for (k = 0; k < 12; k++) begin
            r = $urandom;
            @(posedge sys_clk);
            wp_n_pin <= r[0];
            core_busy <= r[1];
            core_pe_error <= r[2];
            core_wel <= r[3];
            core_soft_protect <= (r[5:4] == 2'h2) ? 2'h3 : r[5:4];
            repeat (3) @(posedge sys_clk);
            wr(1'b0, r[15:8]);
            wr(1'b1, r[23:16]);
            rd(fsr_pkg::OPC_READ_STATUS, 56);
        end
        @(posedge sys_clk);
        freeze_lockdown_stb <= 1'b1;
        @(posedge sys_clk);
        freeze_lockdown_stb <= 1'b0;
        frz_m = 1'b1;
        lde_m = 1'b0;
        wr(1'b1, 8'hFF);
        rd(fsr_pkg::OPC_READ_STATUS, 56);
        for (k = 0; k < 2; k++) begin
            rd(k ? 8'hA0 : 8'h04, 40);
            chk("oe for other code", 8'h00, {7'h0, oe_seen});
        end
        // poll: busy falls mid-run, the host keeps reading until the last byte shows ready
        @(posedge sys_clk);
        core_busy <= 1'b1;
        fork
            begin
                repeat (2000) @(posedge sys_clk);
                core_busy <= 1'b0;
            end
        join_none
        for (k = 0; k < 8; k++) begin
            host.frame(fsr_pkg::OPC_READ_STATUS, 56);
            @(posedge sys_clk);
            if (k == 0) chk("busy while polled", 8'h01, {7'h0, rx_data[0]});
            if (rx_data[0] === 1'b0) break;
        end
        chk("busy fell", 8'h00, {7'h0, rx_data[0]});
        rd(fsr_pkg::OPC_READ_STATUS, 35);
        rd(fsr_pkg::OPC_READ_STATUS, 40);
        final_report();
    end
endmodule : fsr_status_read_tb_top
